//--- rtl/cpuam_decode.v
// Operand fetch sequencer and effective address former of the core.
//
// Behaviour
// - Inherent instructions are one opcode byte only.
// - Immediate takes one byte after the opcode as operand value.
// - Short direct takes one address byte, page zero only.
// - Long direct takes a two byte address word, full space.
// - Indexed address is unsigned index register plus offset.
// - No offset indexed uses the index register itself, no extra byte.
// - Short indexed adds a one byte offset, reach 00 to 1FE.
// - Long indexed adds a two byte offset word, full space.
// - Short indirect reads a byte pointer from a page zero pointer address.
// - Long indirect reads a word pointer from a page zero pointer address.
// - Indirect indexed adds the memory pointer to the index register.
// - Relative adds a signed byte to the next instruction address.
// - Short direct and short indirect address only page zero, 0000h to 00FFh.
// - Memory to memory instructions accept short modes only.
// - No offset indexed with second index costs one byte more.
// - Prebytes 90, 92, 91 select second index, indirect, second indirect index.
// - Short indirect indexed uses a byte pointer, reach 00 to 1FE.
`timescale 1ns/100ps
`default_nettype none
`include "cpuam_map.vh"
module cpuam_decode
(
   input wire ref_clk,
   input wire rstn,
   input wire start,
   input wire [15:0] start_pc,
   input wire [3:0] mode,
   input wire mem_to_mem,
   input wire [7:0] idx_x,
   input wire [7:0] idx_y,
   output wire mem_req,
   output reg [15:0] mem_addr,
   input wire mem_ack,
   input wire [7:0] mem_rdata,
   output reg busy,
   output reg done,
   output reg mode_error,
   output reg [7:0] prebyte_seen,
   output reg [7:0] opcode,
   output reg [7:0] operand,
   output reg operand_valid,
   output reg [15:0] ea,
   output reg ea_valid,
   output reg [15:0] pc_next,
   output reg [2:0] length
);
   localparam ST_IDLE = 3'h0;
   localparam ST_OPC = 3'h1;
   localparam ST_ARG_HI = 3'h2;
   localparam ST_ARG_LO = 3'h3;
   localparam ST_PTR_HI = 3'h4;
   localparam ST_PTR_LO = 3'h5;
   localparam ST_CALC = 3'h6;

   reg [2:0] state_ff, nxt_state;
   reg [15:0] pc_ff, nxt_pc;
   reg [15:0] arg_ff, nxt_arg;
   reg [15:0] ptr_ff, nxt_ptr;
   reg [7:0] pre_ff, nxt_pre;
   reg [7:0] opc_ff, nxt_opc;
   reg [2:0] len_ff, nxt_len;
   reg req_ff, nxt_req;
   reg [15:0] addr_ff, nxt_addr;

   // Resolved mode after prebyte application; prebytes only retarget existing forms.
   reg [3:0] eff_mode;
   reg use_y;
   always @*
   begin
      eff_mode = mode;
      use_y = 1'b0;
      if (pre_ff == `CPUAM_PRE_Y)
         use_y = 1'b1;
      else if (pre_ff == `CPUAM_PRE_IND_Y)
         use_y = 1'b1;
      if (pre_ff == `CPUAM_PRE_IND || pre_ff == `CPUAM_PRE_IND_Y)
      begin
         case (mode)
            `CPUAM_M_DIR_S: eff_mode = `CPUAM_M_IND_S;
            `CPUAM_M_DIR_L: eff_mode = `CPUAM_M_IND_L;
            `CPUAM_M_IX_S: eff_mode = `CPUAM_M_IIX_S;
            `CPUAM_M_IX_L: eff_mode = `CPUAM_M_IIX_L;
            `CPUAM_M_REL: eff_mode = `CPUAM_M_REL_IND;
            `CPUAM_M_BIT: eff_mode = `CPUAM_M_BIT_IND;
            default: eff_mode = mode;
         endcase
      end
   end

   // Classification of the resolved mode into fetch counts.
   function [1:0] arg_bytes;
      input [3:0] m;
      begin
         case (m)
            `CPUAM_M_INH, `CPUAM_M_IX_0: arg_bytes = 2'h0;
            `CPUAM_M_DIR_L, `CPUAM_M_IX_L: arg_bytes = 2'h2;
            default: arg_bytes = 2'h1;
         endcase
      end
   endfunction

   function [1:0] ptr_bytes;
      input [3:0] m;
      begin
         case (m)
            `CPUAM_M_IND_L, `CPUAM_M_IIX_L: ptr_bytes = 2'h2;
            `CPUAM_M_IND_S, `CPUAM_M_IIX_S, `CPUAM_M_REL_IND, `CPUAM_M_BIT_IND:
               ptr_bytes = 2'h1;
            default: ptr_bytes = 2'h0;
         endcase
      end
   endfunction

   wire [1:0] n_arg = arg_bytes(eff_mode);
   wire [1:0] n_ptr = ptr_bytes(eff_mode);
   wire is_long = (eff_mode == `CPUAM_M_DIR_L) || (eff_mode == `CPUAM_M_IX_L) ||
      (eff_mode == `CPUAM_M_IND_L) || (eff_mode == `CPUAM_M_IIX_L);
   wire is_idx = (eff_mode == `CPUAM_M_IX_0) || (eff_mode == `CPUAM_M_IX_S) ||
      (eff_mode == `CPUAM_M_IX_L) || (eff_mode == `CPUAM_M_IIX_S) ||
      (eff_mode == `CPUAM_M_IIX_L);
   wire is_rel = (eff_mode == `CPUAM_M_REL) || (eff_mode == `CPUAM_M_REL_IND);
   wire is_ptr = (n_ptr != 2'h0);
   wire [7:0] idx_val = use_y ? idx_y : idx_x;
   wire mem_to_mem_bad = mem_to_mem & is_long;

   // Base of the address sum: the pointer for indirect forms, else the argument.
   wire [15:0] base = is_ptr ? ptr_ff : arg_ff;
   wire [7:0] rel_off = is_ptr ? ptr_ff[7:0] : arg_ff[7:0];
   wire [15:0] ea_sum;
   cpuam_ea_calc u_ea
   (
      .base(base),
      .index(idx_val),
      .use_index(is_idx),
      .rel_off(rel_off),
      .use_rel(is_rel),
      .pc_next(pc_ff),
      .ea(ea_sum)
   );

   assign mem_req = req_ff;

   // Sequencer: one memory read per fetch state, ST_OPC one more for a prebyte, each held until acknowledged.
   always @*
   begin
      nxt_state = state_ff;
      nxt_pc = pc_ff;
      nxt_arg = arg_ff;
      nxt_ptr = ptr_ff;
      nxt_pre = pre_ff;
      nxt_opc = opc_ff;
      nxt_len = len_ff;
      nxt_req = req_ff;
      nxt_addr = addr_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (start)
            begin
               nxt_state = ST_OPC;
               nxt_pc = start_pc;
               nxt_addr = start_pc;
               nxt_req = 1'b1;
               nxt_pre = `CPUAM_BYTE0;
               nxt_len = 3'h0;
               nxt_arg = `CPUAM_ZERO16;
               nxt_ptr = `CPUAM_ZERO16;
            end
         end
         ST_OPC:
         begin
            if (mem_ack)
            begin
               nxt_pc = pc_ff + `CPUAM_ONE16;
               nxt_addr = pc_ff + `CPUAM_ONE16;
               nxt_len = len_ff + 3'h1;
               if ((mem_rdata == `CPUAM_PRE_Y || mem_rdata == `CPUAM_PRE_IND ||
                  mem_rdata == `CPUAM_PRE_IND_Y) && pre_ff == `CPUAM_BYTE0)
                  nxt_pre = mem_rdata;
               else
               begin
                  nxt_opc = mem_rdata;
                  nxt_state = ST_ARG_HI;
                  nxt_req = 1'b0;
               end
            end
         end
         ST_ARG_HI:
         begin
            // One idle cycle lets eff_mode settle on the latched prebyte.
            if (!req_ff)
            begin
               if (n_arg == 2'h0)
               begin
                  nxt_state = ST_CALC;
               end
               else
                  nxt_req = 1'b1;
            end
            else if (mem_ack)
            begin
               nxt_pc = pc_ff + `CPUAM_ONE16;
               nxt_addr = pc_ff + `CPUAM_ONE16;
               nxt_len = len_ff + 3'h1;
               nxt_arg = {`CPUAM_PAGE0_HI, mem_rdata};
               if (n_arg == 2'h2)
                  nxt_state = ST_ARG_LO;
               else if (is_ptr)
               begin
                  nxt_state = ST_PTR_HI;
                  nxt_addr = {`CPUAM_PAGE0_HI, mem_rdata};
               end
               else
               begin
                  nxt_state = ST_CALC;
                  nxt_req = 1'b0;
               end
            end
         end
         ST_ARG_LO:
         begin
            if (mem_ack)
            begin
               nxt_pc = pc_ff + `CPUAM_ONE16;
               nxt_len = len_ff + 3'h1;
               nxt_arg = {arg_ff[7:0], mem_rdata};
               nxt_state = ST_CALC;
               nxt_req = 1'b0;
            end
         end
         ST_PTR_HI:
         begin
            if (mem_ack)
            begin
               nxt_ptr = {`CPUAM_PAGE0_HI, mem_rdata};
               nxt_addr = addr_ff + `CPUAM_ONE16;
               if (n_ptr == 2'h2)
                  nxt_state = ST_PTR_LO;
               else
               begin
                  nxt_state = ST_CALC;
                  nxt_req = 1'b0;
               end
            end
         end
         ST_PTR_LO:
         begin
            if (mem_ack)
            begin
               nxt_ptr = {ptr_ff[7:0], mem_rdata};
               nxt_state = ST_CALC;
               nxt_req = 1'b0;
            end
         end
         ST_CALC:
            nxt_state = ST_IDLE;
         default:
         begin
            nxt_state = ST_IDLE;
            nxt_req = 1'b0;
         end
      endcase
   end

   // State registers take constants only under reset.
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= ST_IDLE;
         pc_ff <= `CPUAM_ZERO16;
         arg_ff <= `CPUAM_ZERO16;
         ptr_ff <= `CPUAM_ZERO16;
         pre_ff <= `CPUAM_BYTE0;
         opc_ff <= `CPUAM_BYTE0;
         len_ff <= 3'h0;
         req_ff <= 1'b0;
         addr_ff <= `CPUAM_ZERO16;
      end
      else
      begin
         state_ff <= nxt_state;
         pc_ff <= nxt_pc;
         arg_ff <= nxt_arg;
         ptr_ff <= nxt_ptr;
         pre_ff <= nxt_pre;
         opc_ff <= nxt_opc;
         len_ff <= nxt_len;
         req_ff <= nxt_req;
         addr_ff <= nxt_addr;
      end
   end

   // Registered results; done pulses one cycle with all results valid together.
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mem_addr <= `CPUAM_ZERO16;
         busy <= 1'b0;
         done <= 1'b0;
         mode_error <= 1'b0;
         prebyte_seen <= `CPUAM_BYTE0;
         opcode <= `CPUAM_BYTE0;
         operand <= `CPUAM_BYTE0;
         operand_valid <= 1'b0;
         ea <= `CPUAM_ZERO16;
         ea_valid <= 1'b0;
         pc_next <= `CPUAM_ZERO16;
         length <= 3'h0;
      end
      else
      begin
         mem_addr <= nxt_addr;
         busy <= (nxt_state != ST_IDLE);
         done <= (state_ff == ST_CALC);
         if (state_ff == ST_CALC)
         begin
            prebyte_seen <= pre_ff;
            opcode <= opc_ff;
            pc_next <= pc_ff;
            length <= len_ff;
            mode_error <= mem_to_mem_bad;
            operand_valid <= (eff_mode == `CPUAM_M_IMM);
            operand <= arg_ff[7:0];
            ea_valid <= (eff_mode != `CPUAM_M_INH) && (eff_mode != `CPUAM_M_IMM) &&
               !mem_to_mem_bad;
            ea <= ea_sum;
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/cpuam_map.vh
// Constants of the addressing mode decoder: prebytes, mode codes, address limits.
`ifndef CPUAM_MAP_VH
`define CPUAM_MAP_VH
`define CPUAM_PRE_Y 8'h90
`define CPUAM_PRE_IND 8'h92
`define CPUAM_PRE_IND_Y 8'h91
`define CPUAM_M_INH 4'h0
`define CPUAM_M_IMM 4'h1
`define CPUAM_M_DIR_S 4'h2
`define CPUAM_M_DIR_L 4'h3
`define CPUAM_M_IX_0 4'h4
`define CPUAM_M_IX_S 4'h5
`define CPUAM_M_IX_L 4'h6
`define CPUAM_M_IND_S 4'h7
`define CPUAM_M_IND_L 4'h8
`define CPUAM_M_IIX_S 4'h9
`define CPUAM_M_IIX_L 4'hA
`define CPUAM_M_REL 4'hB
`define CPUAM_M_REL_IND 4'hC
`define CPUAM_M_BIT 4'hD
`define CPUAM_M_BIT_IND 4'hE
`define CPUAM_PAGE0_HI 8'h00
`define CPUAM_BYTE0 8'h00
`define CPUAM_ZERO16 16'h0000
`define CPUAM_ONE16 16'h0001
`endif

//--- rtl/cpuam_ea_calc.v
// Effective address adder for indexed and relative forms.
`timescale 1ns/100ps
`default_nettype none
module cpuam_ea_calc
(
   input wire [15:0] base,
   input wire [7:0] index,
   input wire use_index,
   input wire [7:0] rel_off,
   input wire use_rel,
   input wire [15:0] pc_next,
   output wire [15:0] ea
);
   // Unsigned index add; the carry out of a short sum lands in bit 8, giving up to 1FE.
   wire [15:0] idx_sum;
   wire [15:0] rel_sum;
   assign idx_sum = base + (use_index ? {8'h00, index} : 16'h0000);
   // Sign extension of the offset gives the -128 to +127 reach.
   assign rel_sum = pc_next + {{8{rel_off[7]}}, rel_off};
   assign ea = use_rel ? rel_sum : idx_sum;
endmodule
`default_nettype wire

//--- bench/cpuam_decode_sva.sv
// Checker of the operand fetch sequencer at its ports.
`timescale 1ns/100ps
`default_nettype none
`include "cpuam_map.vh"
module cpuam_decode_sva
(
   input wire ref_clk,
   input wire rstn,
   input wire start,
   input wire [15:0] start_pc,
   input wire [3:0] mode,
   input wire mem_to_mem,
   input wire [7:0] idx_x,
   input wire mem_req,
   input wire [15:0] mem_addr,
   input wire mem_ack,
   input wire busy,
   input wire done,
   input wire mode_error,
   input wire [7:0] prebyte_seen,
   input wire operand_valid,
   input wire [15:0] ea,
   input wire ea_valid,
   input wire [15:0] pc_next,
   input wire [2:0] length
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // A start taken while idle, and an instruction finished without a prebyte.
   sequence s_take;
      start && !busy && !done;
   endsequence
   sequence s_plain(logic [3:0] m);
      done && prebyte_seen == 8'h00 && mode == m;
   endsequence
   // The first read goes to the start address.
   first_fetch_a: assert property (s_take |=> mem_req && mem_addr == start_pc)
      else $error("first read not at start address");
   // Busy covers at least the shortest decode and is down once results come out.
   busy_span_a: assert property (s_take |=> busy [*3])
      else $error("busy not held through decode");
   done_idle_a: assert property (done |-> !busy)
      else $error("busy still high at done");
   req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("read request dropped or moved before answer");
   done_pulse_a: assert property (done |=> !done)
      else $error("done longer than one cycle");
   next_pc_a: assert property (done |-> pc_next == start_pc + length)
      else $error("next address differs from start plus length");
   inh_len_a: assert property (s_plain(`CPUAM_M_INH) |-> length == 3'h1 && !ea_valid)
      else $error("inherent length wrong");
   imm_len_a: assert property (s_plain(`CPUAM_M_IMM) |-> length == 3'h2 && operand_valid)
      else $error("immediate length wrong");
   dir_page_a: assert property (s_plain(`CPUAM_M_DIR_S) |-> ea[15:8] == 8'h00)
      else $error("short direct left page zero");
   ix0_addr_a: assert property (s_plain(`CPUAM_M_IX_0) |-> ea == {8'h00, idx_x})
      else $error("no offset indexed address wrong");
   m2m_long_a: assert property (done && mem_to_mem && (mode == `CPUAM_M_DIR_L ||
      mode == `CPUAM_M_IX_L) |-> mode_error && !ea_valid)
      else $error("long mode accepted for memory to memory");
endmodule
bind cpuam_decode cpuam_decode_sva i_sva (.ref_clk(ref_clk), .rstn(rstn), .start(start),
   .start_pc(start_pc), .mode(mode), .mem_to_mem(mem_to_mem), .idx_x(idx_x),
   .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .busy(busy), .done(done),
   .mode_error(mode_error), .prebyte_seen(prebyte_seen), .operand_valid(operand_valid),
   .ea(ea), .ea_valid(ea_valid), .pc_next(pc_next), .length(length));
`default_nettype wire

//--- bench/cpuam_mem_model.sv
// Byte memory answering the core's reads after a settable wait.
`timescale 1ns/100ps
`default_nettype none
module cpuam_mem_model
(
   input wire ref_clk,
   input wire rstn,
   input wire mem_req,
   input wire [15:0] mem_addr,
   input wire [1:0] n_wait,
   output logic mem_ack,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [1:0] cnt_ff;
   logic [7:0] last_ff;
   // Outside an answer the data shows the inverse of the last byte, so stale data fails.
   assign mem_ack = mem_req && cnt_ff == n_wait;
   assign mem_rdata = mem_ack ? mem[mem_addr] : ~last_ff;
   // Wait counter and last byte delivered.
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_ff <= 2'h0;
         last_ff <= 8'h00;
      end
      else if (mem_ack)
      begin
         cnt_ff <= 2'h0;
         last_ff <= mem_rdata;
      end
      else if (mem_req)
         cnt_ff <= cnt_ff + 2'h1;
   end
endmodule
`default_nettype wire

//--- bench/test_cpu_addressing_mode_decode.sv
// Self-checking bench of the addressing mode decoder.
`timescale 1ns/100ps
`default_nettype none
`include "cpuam_map.vh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
   $display("mismatch %s expected %h seen %h", nm, e, s); end end
module test_cpu_addressing_mode_decode;
   logic ref_clk = 1'b0, rstn = 1'b0, start = 1'b0, mem_to_mem = 1'b0;
   logic [15:0] start_pc = 16'h0000;
   logic [3:0] mode = 4'h0;
   logic [7:0] idx_x = 8'h00, idx_y = 8'h00;
   logic [1:0] n_wait = 2'h0;
   wire mem_req, mem_ack, busy, done, mode_error, operand_valid, ea_valid;
   wire [15:0] mem_addr, ea, pc_next;
   wire [7:0] mem_rdata, prebyte_seen, opcode, operand;
   wire [2:0] length;
   int n_fail = 0, n_tests = 0;
   cpuam_decode i_dut (.ref_clk(ref_clk), .rstn(rstn), .start(start), .start_pc(start_pc),
      .mode(mode), .mem_to_mem(mem_to_mem), .idx_x(idx_x), .idx_y(idx_y),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .busy(busy), .done(done), .mode_error(mode_error), .prebyte_seen(prebyte_seen),
      .opcode(opcode), .operand(operand), .operand_valid(operand_valid), .ea(ea),
      .ea_valid(ea_valid), .pc_next(pc_next), .length(length));
   cpuam_mem_model i_mem (.ref_clk(ref_clk), .rstn(rstn), .mem_req(mem_req),
      .mem_addr(mem_addr), .n_wait(n_wait), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // Free running core clock.
   initial forever #4 ref_clk = ~ref_clk;
   task automatic test_done;
      $display("compares %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Fixed byte arguments keep the loader plain for every simulator; n says how many land.
   task automatic put(input logic [15:0] a, input int n, input logic [7:0] b0,
      input logic [7:0] b1, input logic [7:0] b2);
      if (n > 0)
         i_mem.mem[a] = b0;
      if (n > 1)
         i_mem.mem[a + 16'h0001] = b1;
      if (n > 2)
         i_mem.mem[a + 16'h0002] = b2;
   endtask
   // One decode; the wait is bounded so a hung sequencer ends the run.
   task automatic run(input logic [15:0] pc, input logic [3:0] m, input logic [2:0] len,
      input logic [15:0] xea, input logic xev);
      int k;
      @(negedge ref_clk);
      start_pc = pc;
      mode = m;
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      for (k = 0; k < 60 && done !== 1'b1; k++)
         @(negedge ref_clk);
      `CHK("done", 1'b1, done)
      if (done !== 1'b1)
         test_done();
      `CHK("length", len, length)
      `CHK("pc_next", pc + len, pc_next)
      `CHK("ea_valid", xev, ea_valid)
      if (xev)
         `CHK("ea", xea, ea)
   endtask
   task automatic t_basic;
      put(16'h0100, 1, 8'h9D, 8'h00, 8'h00);
      run(16'h0100, `CPUAM_M_INH, 3'h1, 16'h0000, 1'b0);
      `CHK("opcode", 8'h9D, opcode)
      put(16'h0110, 2, 8'hA6, 8'h55, 8'h00);
      run(16'h0110, `CPUAM_M_IMM, 3'h2, 16'h0000, 1'b0);
      `CHK("operand", 8'h55, operand)
      `CHK("operand_valid", 1'b1, operand_valid)
      put(16'h0120, 2, 8'hB6, 8'h80, 8'h00);
      run(16'h0120, `CPUAM_M_DIR_S, 3'h2, 16'h0080, 1'b1);
      n_wait = 2'h2;
      put(16'h0130, 3, 8'hC6, 8'h12, 8'h34);
      run(16'h0130, `CPUAM_M_DIR_L, 3'h3, 16'h1234, 1'b1);
      n_wait = 2'h0;
      $display("basic modes done");
   endtask
   task automatic t_idx;
      idx_x = 8'hF0;
      idx_y = 8'h33;
      put(16'h0140, 1, 8'hF6, 8'h00, 8'h00);
      run(16'h0140, `CPUAM_M_IX_0, 3'h1, 16'h00F0, 1'b1);
      put(16'h0150, 2, 8'h90, 8'hF6, 8'h00);
      run(16'h0150, `CPUAM_M_IX_0, 3'h2, 16'h0033, 1'b1);
      `CHK("prebyte", 8'h90, prebyte_seen)
      idx_x = 8'hFF;
      put(16'h0160, 2, 8'hE6, 8'hFF, 8'h00);
      run(16'h0160, `CPUAM_M_IX_S, 3'h2, 16'h01FE, 1'b1);
      idx_x = 8'h20;
      put(16'h0170, 3, 8'hD6, 8'h12, 8'hF0);
      run(16'h0170, `CPUAM_M_IX_L, 3'h3, 16'h1310, 1'b1);
      $display("indexed modes done");
   endtask
   task automatic t_ind;
      put(16'h0040, 1, 8'h7A, 8'h00, 8'h00);
      put(16'h0180, 3, 8'h92, 8'hB6, 8'h40);
      run(16'h0180, `CPUAM_M_DIR_S, 3'h3, 16'h007A, 1'b1);
      put(16'h0050, 2, 8'hAB, 8'hCD, 8'h00);
      put(16'h0190, 3, 8'h92, 8'hC6, 8'h50);
      run(16'h0190, `CPUAM_M_DIR_L, 3'h3, 16'hABCD, 1'b1);
      idx_x = 8'hFF;
      put(16'h0060, 1, 8'hFF, 8'h00, 8'h00);
      put(16'h01A0, 3, 8'h92, 8'hE6, 8'h60);
      run(16'h01A0, `CPUAM_M_IX_S, 3'h3, 16'h01FE, 1'b1);
      idx_y = 8'h10;
      put(16'h0070, 2, 8'h20, 8'h00, 8'h00);
      put(16'h01B0, 3, 8'h91, 8'hD6, 8'h70);
      run(16'h01B0, `CPUAM_M_IX_L, 3'h3, 16'h2010, 1'b1);
      $display("indirect modes done");
   endtask
   task automatic t_rel_m2m;
      put(16'h0200, 2, 8'h26, 8'h80, 8'h00);
      run(16'h0200, `CPUAM_M_REL, 3'h2, 16'h0182, 1'b1);
      put(16'h0210, 2, 8'h26, 8'h7F, 8'h00);
      run(16'h0210, `CPUAM_M_REL, 3'h2, 16'h0291, 1'b1);
      // Indirect relative and both bit forms; the pointer byte sits at 0048.
      put(16'h0048, 1, 8'hF0, 8'h00, 8'h00);
      put(16'h0240, 3, 8'h92, 8'h26, 8'h48);
      run(16'h0240, `CPUAM_M_REL, 3'h3, 16'h0233, 1'b1);
      put(16'h0250, 2, 8'h10, 8'h44, 8'h00);
      run(16'h0250, `CPUAM_M_BIT, 3'h2, 16'h0044, 1'b1);
      put(16'h0260, 3, 8'h92, 8'h10, 8'h48);
      run(16'h0260, `CPUAM_M_BIT, 3'h3, 16'h00F0, 1'b1);
      mem_to_mem = 1'b1;
      put(16'h0220, 2, 8'h3C, 8'h80, 8'h00);
      run(16'h0220, `CPUAM_M_DIR_S, 3'h2, 16'h0080, 1'b1);
      `CHK("mode_error", 1'b0, mode_error)
      put(16'h0230, 3, 8'hCC, 8'h12, 8'h34);
      run(16'h0230, `CPUAM_M_DIR_L, 3'h3, 16'h0000, 1'b0);
      `CHK("mode_error", 1'b1, mode_error)
      mem_to_mem = 1'b0;
      $display("relative and memory to memory done");
   endtask
   // Reset, then the scenarios in turn.
   initial
   begin
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      t_basic();
      t_idx();
      t_ind();
      t_rel_m2m();
      test_done();
   end
endmodule
`default_nettype wire
